// >>> odtb_params.svh
// Purpose: offsets, field positions, reset values and counts of the debug block
// Assumes: 8-bit register port, one clock
// Notes: included by the debug top module and by the bench
`ifndef ODTB_PARAMS_SVH
`define ODTB_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ODTB_OFS_BKPT_H 8'h00
`define ODTB_OFS_BKPT_L 8'h01
`define ODTB_OFS_BDC_SC 8'h02
`define ODTB_OFS_CMPA_H 8'h03
`define ODTB_OFS_CMPA_L 8'h04
`define ODTB_OFS_CMPB_H 8'h05
`define ODTB_OFS_CMPB_L 8'h06
`define ODTB_OFS_FIFO_H 8'h07
`define ODTB_OFS_FIFO_L 8'h08
`define ODTB_OFS_CTRL 8'h09
`define ODTB_OFS_TRIG 8'h0A
`define ODTB_OFS_STAT 8'h0B

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ODTB_BDC_EN_BIT 7
`define ODTB_BDC_FTS_BIT 6
`define ODTB_CTRL_ARM_BIT 7
`define ODTB_CTRL_BRKEN_BIT 6
`define ODTB_CTRL_TAG_BIT 5
`define ODTB_CTRL_COMP_A_RW_QUALIFY_ENABLE_BIT 4
`define ODTB_CTRL_RWA_BIT 3
`define ODTB_CTRL_RWBEN_BIT 2
`define ODTB_CTRL_RWB_BIT 1
`define ODTB_TRIG_SEL_BIT 7
`define ODTB_TRIG_BEGIN_BIT 6

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define ODTB_REG8_RST 8'h00
`define ODTB_REG16_RST 16'h0000
`define ODTB_FIFO_DEPTH 8
`define ODTB_COF_SKIP 2'h2

`endif

// >>> odtb_pkg.sv
// Purpose: types shared by the debug block
// Assumes: nothing
// Notes: constants live in odtb_params.svh
package odtb_pkg;

   // -------------------------------------------------------------------
   // cpu bus cycle and change-of-flow report
   // -------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic rw;
      logic opfetch;
      logic bdc;
      logic [15:0] addr;
      logic [7:0] rdata;
      logic [7:0] wdata;
   } odtb_cpu_bus_t;

   typedef enum logic [1:0] {
      ODTB_COF_COND_TAKEN = 2'h0,
      ODTB_COF_BRA_BRN = 2'h1,
      ODTB_COF_INDIRECT = 2'h2,
      ODTB_COF_INT_RET = 2'h3
   } odtb_cof_kind_t;

   typedef struct packed {
      logic valid;
      odtb_cof_kind_t kind;
      logic [15:0] src;
      logic [15:0] dst;
   } odtb_cof_t;

   // -------------------------------------------------------------------
   // trigger modes and run states
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      ODTB_M_A_ONLY = 4'h0,
      ODTB_M_A_OR_B = 4'h1,
      ODTB_M_A_THEN_B = 4'h2,
      ODTB_M_EV_B = 4'h3,
      ODTB_M_A_THEN_EV_B = 4'h4,
      ODTB_M_A_AND_D = 4'h5,
      ODTB_M_A_NOT_D = 4'h6,
      ODTB_M_INSIDE = 4'h7,
      ODTB_M_OUTSIDE = 4'h8
   } odtb_mode_t;

   typedef enum logic [4:0] {
      ODTB_ST_IDLE = 5'h01,
      ODTB_ST_BEGIN_WAIT = 5'h02,
      ODTB_ST_BEGIN_STORE = 5'h04,
      ODTB_ST_END_STORE = 5'h08,
      ODTB_ST_EVENT = 5'h10
   } odtb_state_t;

endpackage

// >>> odtb_top.sv
// Purpose: background breakpoint, two comparators and capture fifo
// Assumes: cpu signals on clock_i; register port reads answer next cycle
// Notes: bdm_tag_o is combinational and accompanies the opcode fetch
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "odtb_params.svh"

module odtb_top #(
   parameter int DEPTH = `ODTB_FIFO_DEPTH
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire odtb_pkg::odtb_cpu_bus_t cpu_i,
   input wire logic exec_valid_i,
   input wire logic [15:0] exec_addr_i,
   input wire logic boundary_i,
   input wire odtb_pkg::odtb_cof_t cof_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic bdm_force_req_o,
   output logic bdm_tag_o
);

   localparam int CW = $clog2(DEPTH + 1);

   // -------------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------------
   logic rst_s1_q;
   logic rst_sync_b_q;

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_s1_q <= 1'b0;
         rst_sync_b_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_sync_b_q <= rst_s1_q;
      end
   end

   // -------------------------------------------------------------------
   // registers written by software
   // -------------------------------------------------------------------
   logic [15:0] bkpt_q;
   logic [15:0] cmpa_q;
   logic [15:0] cmpb_q;
   logic [7:0] bdc_sc_q;
   logic [7:0] ctrl_q;
   logic [7:0] trig_q;

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
      begin
         bkpt_q <= `ODTB_REG16_RST;
         cmpa_q <= `ODTB_REG16_RST;
         cmpb_q <= `ODTB_REG16_RST;
         bdc_sc_q <= `ODTB_REG8_RST;
         ctrl_q <= `ODTB_REG8_RST;
         trig_q <= `ODTB_REG8_RST;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `ODTB_OFS_BKPT_H: bkpt_q[15:8] <= reg_wdata_i;
            `ODTB_OFS_BKPT_L: bkpt_q[7:0] <= reg_wdata_i;
            `ODTB_OFS_BDC_SC: bdc_sc_q <= reg_wdata_i;
            `ODTB_OFS_CMPA_H: cmpa_q[15:8] <= reg_wdata_i;
            `ODTB_OFS_CMPA_L: cmpa_q[7:0] <= reg_wdata_i;
            `ODTB_OFS_CMPB_H: cmpb_q[15:8] <= reg_wdata_i;
            `ODTB_OFS_CMPB_L: cmpb_q[7:0] <= reg_wdata_i;
            `ODTB_OFS_CTRL: ctrl_q <= reg_wdata_i;
            `ODTB_OFS_TRIG: trig_q <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   logic arm_wr;
   logic disarm_wr;
   logic pop;
   logic peek;
   assign arm_wr = reg_wr_i && reg_addr_i == `ODTB_OFS_CTRL && reg_wdata_i[`ODTB_CTRL_ARM_BIT];
   assign disarm_wr = reg_wr_i && reg_addr_i == `ODTB_OFS_CTRL && !reg_wdata_i[`ODTB_CTRL_ARM_BIT];
   assign pop = reg_rd_i && reg_addr_i == `ODTB_OFS_FIFO_L;
   assign peek = reg_rd_i && reg_addr_i == `ODTB_OFS_FIFO_H;

   // -------------------------------------------------------------------
   // comparators
   // -------------------------------------------------------------------
   function automatic logic rw_ok(input logic en, input logic val, input logic rw);
      rw_ok = !en || (val == rw);
   endfunction

   function automatic logic is_event(input odtb_pkg::odtb_mode_t m);
      is_event = (m == odtb_pkg::ODTB_M_EV_B) || (m == odtb_pkg::ODTB_M_A_THEN_EV_B);
   endfunction

   odtb_pkg::odtb_mode_t mode;
   odtb_pkg::odtb_state_t state_q;
   logic af_q;
   logic bf_q;
   logic armed;
   logic use_exec;
   logic cmp_ok;
   logic cmp_rw;
   logic [15:0] cmp_addr;
   logic [7:0] data_sel;
   logic match_a;
   logic match_b;
   logic match_d;
   logic ge_a;
   logic le_b;
   logic full_mode;
   logic trig;

   assign mode = odtb_pkg::odtb_mode_t'(trig_q[3:0]);
   assign armed = state_q != odtb_pkg::ODTB_ST_IDLE;
   assign use_exec = trig_q[`ODTB_TRIG_SEL_BIT];
   assign cmp_ok = !cpu_i.bdc && (use_exec ? exec_valid_i : cpu_i.valid);
   assign cmp_addr = use_exec ? exec_addr_i : cpu_i.addr;
   assign cmp_rw = use_exec ? 1'b1 : cpu_i.rw;
   assign match_a = cmp_ok && cmp_addr == cmpa_q
      && rw_ok(ctrl_q[`ODTB_CTRL_COMP_A_RW_QUALIFY_ENABLE_BIT], ctrl_q[`ODTB_CTRL_RWA_BIT], cmp_rw);
   assign match_b = cmp_ok && cmp_addr == cmpb_q
      && rw_ok(ctrl_q[`ODTB_CTRL_RWBEN_BIT], ctrl_q[`ODTB_CTRL_RWB_BIT], cmp_rw);
   assign data_sel = (ctrl_q[`ODTB_CTRL_COMP_A_RW_QUALIFY_ENABLE_BIT] && !ctrl_q[`ODTB_CTRL_RWA_BIT])
      ? cpu_i.wdata : cpu_i.rdata;
   assign match_d = data_sel == cmpb_q[7:0];
   assign ge_a = cmp_addr >= cmpa_q;
   assign le_b = cmp_addr <= cmpb_q;
   assign full_mode = mode == odtb_pkg::ODTB_M_A_AND_D || mode == odtb_pkg::ODTB_M_A_NOT_D;

   always_comb
   begin
      trig = 1'b0;
      case (mode)
         odtb_pkg::ODTB_M_A_ONLY: trig = match_a;
         odtb_pkg::ODTB_M_A_OR_B: trig = match_a || match_b;
         odtb_pkg::ODTB_M_A_THEN_B: trig = af_q && match_b;
         odtb_pkg::ODTB_M_EV_B: trig = match_b;
         odtb_pkg::ODTB_M_A_THEN_EV_B: trig = af_q && match_b;
         odtb_pkg::ODTB_M_A_AND_D: trig = match_a && match_d;
         odtb_pkg::ODTB_M_A_NOT_D: trig = match_a && !match_d;
         odtb_pkg::ODTB_M_INSIDE: trig = match_a || (cmp_ok && ge_a && le_b);
         odtb_pkg::ODTB_M_OUTSIDE: trig = cmp_ok && (!ge_a || !le_b);
         default: trig = 1'b0;
      endcase
   end

   // -------------------------------------------------------------------
   // change-of-flow selection and fifo input
   // -------------------------------------------------------------------
   logic cof_store;
   logic [15:0] cof_word;
   logic [CW-1:0] cnt_q;
   logic [1:0] skip_q;
   logic push;
   logic [15:0] push_val;
   logic [15:0] last_fetch_q;

   assign cof_store = cof_i.valid && cof_i.kind != odtb_pkg::ODTB_COF_BRA_BRN;
   assign cof_word = (cof_i.kind == odtb_pkg::ODTB_COF_COND_TAKEN)
      ? cof_i.src : cof_i.dst;
   assign push = (state_q == odtb_pkg::ODTB_ST_BEGIN_STORE && skip_q == 2'h0 && cof_store)
      || (state_q == odtb_pkg::ODTB_ST_END_STORE && cof_store)
      || (state_q == odtb_pkg::ODTB_ST_EVENT && trig);
   assign push_val = is_event(mode) ? {8'h00, data_sel} : cof_word;

   // -------------------------------------------------------------------
   // run control
   // -------------------------------------------------------------------
   logic last_slot;
   assign last_slot = cnt_q == CW'(DEPTH - 1);

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
      begin
         state_q <= odtb_pkg::ODTB_ST_IDLE;
      end
      else if (disarm_wr)
      begin
         state_q <= odtb_pkg::ODTB_ST_IDLE;
      end
      else if (arm_wr)
      begin
         if (is_event(mode))
            state_q <= odtb_pkg::ODTB_ST_EVENT;
         else if (trig_q[`ODTB_TRIG_BEGIN_BIT])
            state_q <= odtb_pkg::ODTB_ST_BEGIN_WAIT;
         else
            state_q <= odtb_pkg::ODTB_ST_END_STORE;
      end
      else
      begin
         case (state_q)
            odtb_pkg::ODTB_ST_IDLE: ;
            odtb_pkg::ODTB_ST_BEGIN_WAIT:
               if (trig)
                  state_q <= odtb_pkg::ODTB_ST_BEGIN_STORE;
            odtb_pkg::ODTB_ST_BEGIN_STORE, odtb_pkg::ODTB_ST_EVENT:
               if (push && last_slot)
                  state_q <= odtb_pkg::ODTB_ST_IDLE;
            odtb_pkg::ODTB_ST_END_STORE:
               if (trig)
                  state_q <= odtb_pkg::ODTB_ST_IDLE;
            default: state_q <= odtb_pkg::ODTB_ST_IDLE;
         endcase
      end
   end

   // bus cycles to ignore after a begin trigger
   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
         skip_q <= 2'h0;
      else if (state_q == odtb_pkg::ODTB_ST_BEGIN_WAIT && trig)
         skip_q <= `ODTB_COF_SKIP;
      else if (skip_q != 2'h0 && cpu_i.valid)
         skip_q <= skip_q - 2'h1;
   end

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
      begin
         af_q <= 1'b0;
         bf_q <= 1'b0;
      end
      else if (arm_wr)
      begin
         af_q <= 1'b0;
         bf_q <= 1'b0;
      end
      else if (armed)
      begin
         af_q <= af_q || match_a;
         bf_q <= bf_q || (full_mode ? match_a && match_d : match_b);
      end
   end

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
         cnt_q <= '0;
      else if (arm_wr)
         cnt_q <= '0;
      else if (push && cnt_q != CW'(DEPTH))
         cnt_q <= cnt_q + CW'(1);
   end

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
         last_fetch_q <= `ODTB_REG16_RST;
      else if (cpu_i.valid && cpu_i.opfetch && !cpu_i.bdc)
         last_fetch_q <= cpu_i.addr;
   end

   // -------------------------------------------------------------------
   // capture fifo: entry 0 is the read port, new words enter at the top
   // -------------------------------------------------------------------
   logic [15:0] fifo_q [DEPTH];
   logic shift;
   logic halt_shift;
   logic [15:0] shift_in;

   // a hand-stopped run with the fifo not full moves the fifo on by one, leaving one dummy read fewer
   assign halt_shift = disarm_wr && armed && cnt_q != CW'(DEPTH);
   assign shift = push || pop || halt_shift;
   assign shift_in = push ? push_val : (armed ? 16'h0000 : last_fetch_q);

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_stage
         always_ff @(posedge clock_i or negedge rst_sync_b_q)
         begin
            if (!rst_sync_b_q)
               fifo_q[gi] <= `ODTB_REG16_RST;
            else if (shift)
               fifo_q[gi] <= (gi == DEPTH - 1) ? shift_in : fifo_q[(gi + 1) % DEPTH];
         end
      end
   endgenerate

   // high-byte read freezes the word so the low byte matches it
   logic [7:0] hold_lo_q;
   logic hold_v_q;

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
      begin
         hold_lo_q <= `ODTB_REG8_RST;
         hold_v_q <= 1'b0;
      end
      else if (peek)
      begin
         hold_lo_q <= fifo_q[0][7:0];
         hold_v_q <= 1'b1;
      end
      else if (pop)
         hold_v_q <= 1'b0;
   end

   // -------------------------------------------------------------------
   // read data
   // -------------------------------------------------------------------
   logic [7:0] rd_d;
   logic [7:0] rdata_q;

   always_comb
   begin
      rd_d = 8'h00;
      case (reg_addr_i)
         `ODTB_OFS_BKPT_H: rd_d = bkpt_q[15:8];
         `ODTB_OFS_BKPT_L: rd_d = bkpt_q[7:0];
         `ODTB_OFS_BDC_SC: rd_d = bdc_sc_q;
         `ODTB_OFS_CMPA_H: rd_d = cmpa_q[15:8];
         `ODTB_OFS_CMPA_L: rd_d = cmpa_q[7:0];
         `ODTB_OFS_CMPB_H: rd_d = cmpb_q[15:8];
         `ODTB_OFS_CMPB_L: rd_d = cmpb_q[7:0];
         `ODTB_OFS_FIFO_H: rd_d = fifo_q[0][15:8];
         `ODTB_OFS_FIFO_L: rd_d = hold_v_q ? hold_lo_q : fifo_q[0][7:0];
         `ODTB_OFS_CTRL: rd_d = {armed, ctrl_q[6:0]};
         `ODTB_OFS_TRIG: rd_d = trig_q;
         `ODTB_OFS_STAT: rd_d = {af_q, bf_q, armed, 1'b0, 4'(cnt_q)};
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
         rdata_q <= `ODTB_REG8_RST;
      else if (reg_rd_i)
         rdata_q <= rd_d;
   end
   assign reg_rdata_o = rdata_q;

   // -------------------------------------------------------------------
   // breakpoint requests to the cpu
   // -------------------------------------------------------------------
   logic bdc_hit;
   logic dbg_brk;
   logic force_set;
   logic force_q;

   assign bdc_hit = bdc_sc_q[`ODTB_BDC_EN_BIT] && cpu_i.valid && !cpu_i.bdc
      && cpu_i.addr == bkpt_q;
   assign dbg_brk = ctrl_q[`ODTB_CTRL_BRKEN_BIT] && armed;
   assign force_set = (bdc_hit && bdc_sc_q[`ODTB_BDC_FTS_BIT])
      || (dbg_brk && !ctrl_q[`ODTB_CTRL_TAG_BIT] && trig);
   assign bdm_tag_o = cpu_i.opfetch
      && ((bdc_hit && !bdc_sc_q[`ODTB_BDC_FTS_BIT])
      || (dbg_brk && ctrl_q[`ODTB_CTRL_TAG_BIT] && (full_mode ? match_a : trig)));

   always_ff @(posedge clock_i or negedge rst_sync_b_q)
   begin
      if (!rst_sync_b_q)
         force_q <= 1'b0;
      else if (force_set)
         force_q <= 1'b1;
      else if (boundary_i)
         force_q <= 1'b0;
   end
   assign bdm_force_req_o = force_q;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_sync_b_q);

   chk_force_raise: assert property ((bdc_hit && bdc_sc_q[`ODTB_BDC_FTS_BIT])
      |=> bdm_force_req_o) else $error("forced breakpoint not requested");
   chk_force_hold: assert property ((bdm_force_req_o && !boundary_i)
      |=> bdm_force_req_o) else $error("force request dropped before boundary");
   chk_tag_fetch: assert property ((bdc_hit && !bdc_sc_q[`ODTB_BDC_FTS_BIT]
      && cpu_i.opfetch) |-> bdm_tag_o) else $error("tag missing on match fetch");
   chk_bdc_quiet: assert property (cpu_i.bdc |-> !trig && !bdc_hit)
      else $error("match during background access");
   chk_arm_start: assert property (arm_wr |=> armed && cnt_q == '0
      && !af_q && !bf_q) else $error("arm did not start a clean run");
   chk_full_stop: assert property ((push && last_slot && state_q !=
      odtb_pkg::ODTB_ST_END_STORE && !arm_wr && !disarm_wr)
      |=> !armed && cnt_q == CW'(DEPTH)) else $error("full fifo did not end run");
   chk_skip_window: assert property ((state_q == odtb_pkg::ODTB_ST_BEGIN_WAIT && trig
      && !arm_wr && !disarm_wr) |=> skip_q == 2'h2 && !push)
      else $error("change-of-flow stored too early");
   chk_pop_shift: assert property ((pop && !push)
      |=> fifo_q[0] == $past(fifo_q[1])) else $error("low read did not shift");
   chk_profile: assert property ((pop && !armed)
      |=> fifo_q[DEPTH-1] == $past(last_fetch_q)) else $error("profile push wrong");
   chk_event_byte: assert property ((state_q == odtb_pkg::ODTB_ST_EVENT && trig)
      |=> fifo_q[DEPTH-1][15:8] == 8'h00) else $error("event entry high byte used");
   chk_bra_none: assert property ((cof_i.valid && cof_i.kind == odtb_pkg::ODTB_COF_BRA_BRN
      && state_q == odtb_pkg::ODTB_ST_END_STORE && !arm_wr)
      |=> cnt_q == $past(cnt_q)) else $error("unconditional branch stored");

endmodule

// >>> odtb_cpu_model.sv
// Purpose: cpu core model driving bus cycles and change-of-flow reports
// Assumes: one bus cycle per clock, changed right after the rising edge
// Notes: idle address and data lines toggle so stale values never match
`timescale 1ns/1ps
module odtb_cpu_model (
   input wire logic clock_i,
   output odtb_pkg::odtb_cpu_bus_t cpu_o,
   output logic exec_o,
   output logic [15:0] exec_addr_o,
   output logic bnd_o,
   output odtb_pkg::odtb_cof_t cof_o
);
   initial
   begin
      cpu_o = '0;
      exec_o = 1'b0;
      exec_addr_o = 16'h0000;
      bnd_o = 1'b0;
      cof_o = '0;
   end
   // rw, opcode fetch, background access, address, data, cof, boundary
   task automatic cycle(input logic rw, op, bdc, input logic [15:0] a,
      input logic [7:0] d, input odtb_pkg::odtb_cof_t c, input logic b);
      @(posedge clock_i);
      cpu_o <= {1'b1, rw, op, bdc, a, rw ? d : ~d, rw ? ~d : d};
      exec_o <= 1'b0;
      exec_addr_o <= a;
      cof_o <= c;
      bnd_o <= b;
   endtask
   task automatic idle();
      @(posedge clock_i);
      cpu_o <= {4'h0, ~cpu_o.addr, ~cpu_o.rdata, ~cpu_o.wdata};
      exec_o <= 1'b0;
      cof_o <= '0;
      bnd_o <= 1'b0;
      #1;
   endtask
   // an opcode leaves the queue with no bus cycle beside it
   task automatic retire(input logic [15:0] a);
      @(posedge clock_i);
      cpu_o <= {4'h0, ~cpu_o.addr, ~cpu_o.rdata, ~cpu_o.wdata};
      exec_o <= 1'b1;
      exec_addr_o <= a;
      cof_o <= '0;
   endtask
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the debug block
// Assumes: register reads answer one cycle after the strobe
// Notes: random data from a fixed seed
`timescale 1ns/1ps
`include "odtb_params.svh"
module tb;
   logic clock_i, rst_b_i, reg_wr, reg_rd, force_req, tag, exec_v, bnd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, d;
   logic [15:0] bk, exec_a;
   odtb_pkg::odtb_cpu_bus_t cpu;
   odtb_pkg::odtb_cof_t cof, c;
   integer seed = 16046;
   integer bad_count = 0;
   integer check_count = 0;
   integer cycles = 0;
   integer i;
   logic [15:0] exp_q[$];

   odtb_cpu_model u_cpu (.clock_i(clock_i), .cpu_o(cpu), .exec_o(exec_v),
      .exec_addr_o(exec_a), .bnd_o(bnd), .cof_o(cof));
   odtb_top u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cpu_i(cpu),
      .exec_valid_i(exec_v), .exec_addr_i(exec_a), .boundary_i(bnd), .cof_i(cof),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .bdm_force_req_o(force_req),
      .bdm_tag_o(tag));

   initial
   begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   always @(posedge clock_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         bad_count++;
         conclude();
      end
   end
   // ----
   // tasks
   // ----
   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(posedge clock_i);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock_i);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock_i);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   task automatic pop(input logic [15:0] e);
      rd(`ODTB_OFS_FIFO_H);
      check("fifo high", rd_val, e[15:8]);
      rd(`ODTB_OFS_FIFO_L);
      check("fifo low", rd_val, e[7:0]);
   endtask
   task automatic probe(input logic [15:0] a, input logic op, e);
      u_cpu.cycle(1'b1, op, 1'b0, a, 8'h00, '0, 1'b0);
      u_cpu.idle();
      rd(`ODTB_OFS_STAT);
      check("armed", rd_val[5], e);
   endtask
   // expected fifo word of a change-of-flow, bit 16 says stored
   function automatic logic [16:0] cof_word(input odtb_pkg::odtb_cof_t x);
      if (x.kind == odtb_pkg::ODTB_COF_COND_TAKEN)
         return {1'b1, x.src};
      if (x.kind == odtb_pkg::ODTB_COF_BRA_BRN)
         return 17'h00000;
      return {1'b1, x.dst};
   endfunction
   // ----
   // scenarios
   // ----
   initial
   begin
      rst_b_i = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      bk = 16'($random(seed));
      repeat (3) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rd(`ODTB_OFS_BDC_SC);
      check("bdc ctrl", rd_val, 8'h00);
      wr(8'h40, 8'hFF);
      rd(8'h40);
      check("unmapped", rd_val, 8'h00);
      wr(`ODTB_OFS_BKPT_H, bk[15:8]);
      wr(`ODTB_OFS_BKPT_L, bk[7:0]);
      rd(`ODTB_OFS_BKPT_H);
      check("match high", rd_val, bk[15:8]);
      u_cpu.cycle(1'b1, 1'b0, 1'b0, bk, 8'h00, '0, 1'b0);
      u_cpu.idle();
      check("force off", force_req, 1'b0);
      wr(`ODTB_OFS_BDC_SC, 8'hC0);
      u_cpu.cycle(1'b1, 1'b0, 1'b1, bk, 8'h00, '0, 1'b0);
      u_cpu.idle();
      check("force bdc", force_req, 1'b0);
      u_cpu.cycle(1'b0, 1'b0, 1'b0, bk, 8'h5A, '0, 1'b0);
      u_cpu.idle();
      check("force hit", force_req, 1'b1);
      u_cpu.cycle(1'b1, 1'b0, 1'b0, ~bk, 8'h00, '0, 1'b1);
      u_cpu.idle();
      check("force clear", force_req, 1'b0);
      wr(`ODTB_OFS_BDC_SC, 8'h80);
      u_cpu.cycle(1'b1, 1'b1, 1'b0, bk, 8'h00, '0, 1'b0);
      #1 check("tag fetch", tag, 1'b1);
      u_cpu.cycle(1'b1, 1'b0, 1'b0, bk, 8'h00, '0, 1'b0);
      #1 check("tag data", tag, 1'b0);
      u_cpu.idle();
      check("tag force", force_req, 1'b0);
      // event-only b: data words, background access ignored
      wr(`ODTB_OFS_BDC_SC, 8'h00);
      wr(`ODTB_OFS_CMPB_H, bk[15:8]);
      wr(`ODTB_OFS_CMPB_L, bk[7:0]);
      wr(`ODTB_OFS_TRIG, 8'h03);
      wr(`ODTB_OFS_CTRL, 8'h80);
      rd(`ODTB_OFS_STAT);
      check("arm status", {rd_val[5], rd_val[3:0]}, 5'h10);
      u_cpu.cycle(1'b1, 1'b0, 1'b1, bk, 8'hEE, '0, 1'b0);
      for (i = 0; i < 10; i++)
      begin
         d = 8'($random(seed));
         u_cpu.cycle(1'b1, 1'b0, 1'b0, bk, d, '0, 1'b0);
         if (i < 8)
            exp_q.push_back({8'h00, d});
      end
      u_cpu.idle();
      rd(`ODTB_OFS_STAT);
      check("event count", rd_val[3:0], 4'h8);
      while (exp_q.size() > 0)
         pop(exp_q.pop_front());
      // begin trace on a: trigger and two following cofs dropped
      wr(`ODTB_OFS_CTRL, 8'h00);
      wr(`ODTB_OFS_CMPA_H, ~bk[15:8]);
      wr(`ODTB_OFS_CMPA_L, ~bk[7:0]);
      wr(`ODTB_OFS_TRIG, 8'h40);
      wr(`ODTB_OFS_CTRL, 8'h80);
      for (i = 0; i < 40 && exp_q.size() < 8; i++)
      begin
         c = odtb_pkg::odtb_cof_t'({1'b1, 2'(i), 32'($random(seed))});
         u_cpu.cycle(1'b1, 1'b0, 1'b0, (i == 0) ? ~bk : bk, 8'h00, c, 1'b0);
         if (i > 2 && cof_word(c) > 17'h0FFFF)
            exp_q.push_back(cof_word(c));
      end
      u_cpu.idle();
      rd(`ODTB_OFS_STAT);
      check("trace count", rd_val[3:0], 4'h8);
      while (exp_q.size() > 0)
         pop(exp_q.pop_front());
      // profiling while disarmed
      wr(`ODTB_OFS_CTRL, 8'h00);
      u_cpu.cycle(1'b1, 1'b1, 1'b0, bk, 8'h00, '0, 1'b0);
      u_cpu.idle();
      repeat (8) rd(`ODTB_OFS_FIFO_L);
      pop(bk);
      // end trace, full mode on write data: cofs stored up to the trigger
      d = 8'($random(seed));
      wr(`ODTB_OFS_CMPB_L, d);
      wr(`ODTB_OFS_TRIG, 8'h05);
      wr(`ODTB_OFS_CTRL, 8'hD0);
      for (i = 0; i < 3; i++)
      begin
         c = odtb_pkg::odtb_cof_t'({1'b1, 2'((i == 0) ? 1 : 2 * i - 2), 32'($random(seed))});
         u_cpu.cycle(i == 0, 1'b0, 1'b0, ~bk, (i == 1) ? ~d : d, c, 1'b0);
         if (i > 0)
            exp_q.push_back((i == 1) ? c.src : c.dst);
      end
      u_cpu.idle();
      check("brk force", force_req, 1'b1);
      u_cpu.cycle(1'b1, 1'b0, 1'b0, bk, d, c, 1'b1);
      u_cpu.idle();
      rd(`ODTB_OFS_STAT);
      check("end status", rd_val, 8'hC2);
      repeat (6) rd(`ODTB_OFS_FIFO_L);
      while (exp_q.size() > 0)
         pop(exp_q.pop_front());
      // event run stopped by hand after three words
      wr(`ODTB_OFS_TRIG, 8'h03);
      wr(`ODTB_OFS_CTRL, 8'h80);
      for (i = 0; i < 3; i++)
      begin
         exp_q.push_back(16'($random(seed)) & 16'h00FF);
         u_cpu.cycle(1'b1, 1'b0, 1'b0, {bk[15:8], d}, exp_q[i][7:0], '0, 1'b0);
      end
      u_cpu.idle();
      wr(`ODTB_OFS_CTRL, 8'h00);
      rd(`ODTB_OFS_STAT);
      check("halt status", rd_val[5:0], 6'h03);
      repeat (8 - 3 - 1) rd(`ODTB_OFS_FIFO_L);
      while (exp_q.size() > 0)
         pop(exp_q.pop_front());
      // range modes and opcode tracking, each run ended by its trigger
      wr(`ODTB_OFS_CMPA_H, 8'h20);
      wr(`ODTB_OFS_CMPA_L, 8'h00);
      wr(`ODTB_OFS_CMPB_H, 8'h2F);
      wr(`ODTB_OFS_CMPB_L, 8'hFF);
      wr(`ODTB_OFS_TRIG, 8'h07);
      wr(`ODTB_OFS_CTRL, 8'h80);
      probe(16'h1FFF, 1'b0, 1'b1);
      probe(16'h2FFF, 1'b0, 1'b0);
      wr(`ODTB_OFS_TRIG, 8'h08);
      wr(`ODTB_OFS_CTRL, 8'h80);
      probe(16'h2FFF, 1'b0, 1'b1);
      probe(16'h3000, 1'b0, 1'b0);
      wr(`ODTB_OFS_TRIG, 8'h80);
      wr(`ODTB_OFS_CTRL, 8'h80);
      probe(16'h2000, 1'b1, 1'b1);
      u_cpu.retire(16'h2000);
      probe(16'h2000, 1'b0, 1'b0);
      conclude();
   end
endmodule
